// ===== bsf_params.svh
// constant definitions for the bit shift and flag unit
`ifndef BSF_PARAMS_SVH
`define BSF_PARAMS_SVH

// register byte offsets on the avalon slave
`define BSF_ADDR_OPERAND 4'h0
`define BSF_ADDR_CTRL    4'h4
`define BSF_ADDR_FLAGS   4'h8

// control word fields
`define BSF_CTRL_OP_LSB  0
`define BSF_CTRL_OP_MSB  4
`define BSF_CTRL_IDX_LSB 8
`define BSF_CTRL_IDX_MSB 10

// status flag bit positions
`define BSF_FLAG_C 3'h0
`define BSF_FLAG_Z 3'h1
`define BSF_FLAG_N 3'h2
`define BSF_FLAG_V 3'h3
`define BSF_FLAG_S 3'h4
`define BSF_FLAG_H 3'h5
`define BSF_FLAG_T 3'h6
`define BSF_FLAG_I 3'h7

// reset values
`define BSF_RST_OPERAND 8'h00
`define BSF_RST_FLAGS   8'h00
`define BSF_RST_CTRL    11'h000

`endif

// ===== bsf_pkg.sv
// types shared by the bit shift and flag unit
package bsf_pkg;

  typedef enum logic [4:0] {
    OP_ROTATE_LEFT_VIA_CARRY  = 5'h00,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h01,
    OP_ARITH_SHIFT_RIGHT      = 5'h02,
    OP_NIBBLE_EXCHANGE        = 5'h03,
    OP_BIT_TO_TRANSFER_FLAG   = 5'h04,
    OP_TRANSFER_FLAG_TO_BIT   = 5'h05,
    OP_FLAG_FORCE_ONE         = 5'h06,
    OP_FLAG_FORCE_ZERO        = 5'h07,
    OP_CARRY_ON               = 5'h08,
    OP_CARRY_OFF              = 5'h09,
    OP_NEGATIVE_ON            = 5'h0A,
    OP_NEGATIVE_OFF           = 5'h0B,
    OP_ZERO_ON                = 5'h0C,
    OP_ZERO_OFF               = 5'h0D,
    OP_GLOBAL_IRQ_ON          = 5'h0E,
    OP_GLOBAL_IRQ_OFF         = 5'h0F,
    OP_SIGNED_FLAG_ON         = 5'h10,
    OP_SIGNED_FLAG_OFF        = 5'h11,
    OP_OVERFLOW_FLAG_ON       = 5'h12,
    OP_OVERFLOW_FLAG_OFF      = 5'h13,
    OP_TRANSFER_ON            = 5'h14,
    OP_TRANSFER_OFF           = 5'h15
  } bsf_op_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bsf_bus_state_t;

endpackage

// ===== bsf_alu.sv
// combinational shift, rotate, bit-move and flag datapath
`timescale 1ns/1ns
`include "bsf_params.svh"

module bsf_alu (
  input  wire logic            [4:0] op,        // operation code
  input  wire logic            [2:0] bit_idx,   // bit or flag index
  input  wire logic            [7:0] data_in,   // working register value
  input  wire logic            [7:0] flags_in,  // status flags before
  output logic                 [7:0] data_out,  // working register value after
  output logic                 [7:0] flags_out  // status flags after
);

  // zero, carry, negative and overflow from a shifted result
  function automatic logic [7:0] shift_flags(input logic [7:0] f,
                                             input logic [7:0] r,
                                             input logic       c);
    logic [7:0] o;
    o = f;
    o[`BSF_FLAG_C] = c;
    o[`BSF_FLAG_N] = r[7];
    o[`BSF_FLAG_V] = r[7] ^ c;
    o[`BSF_FLAG_Z] = (r == 8'h00);
    return o;
  endfunction

  // named single-flag opcodes: low opcode bit picks clear, pairs pick the flag
  function automatic logic [2:0] named_flag(input logic [4:0] code);
    logic [2:0] i;
    i = `BSF_FLAG_C;
    unique case (code[4:1])
      4'h4:    i = `BSF_FLAG_C;
      4'h5:    i = `BSF_FLAG_N;
      4'h6:    i = `BSF_FLAG_Z;
      4'h7:    i = `BSF_FLAG_I;
      4'h8:    i = `BSF_FLAG_S;
      4'h9:    i = `BSF_FLAG_V;
      default: i = `BSF_FLAG_T;
    endcase
    return i;
  endfunction

  always_comb begin
    data_out  = data_in;
    flags_out = flags_in;
    if (op >= 5'h08 && op <= 5'h15) begin
      flags_out[named_flag(op)] = ~op[0];
    end else begin
      unique case (op)
        5'h00: begin
          data_out  = {data_in[6:0], flags_in[`BSF_FLAG_C]};
          flags_out = shift_flags(flags_in, data_out, data_in[7]);
        end
        5'h01: begin
          data_out  = {flags_in[`BSF_FLAG_C], data_in[7:1]};
          flags_out = shift_flags(flags_in, data_out, data_in[0]);
        end
        5'h02: begin
          data_out  = {data_in[7], data_in[7:1]};
          flags_out = shift_flags(flags_in, data_out, data_in[0]);
        end
        5'h03: data_out = {data_in[3:0], data_in[7:4]};
        5'h04: flags_out[`BSF_FLAG_T] = data_in[bit_idx];
        5'h05: data_out[bit_idx] = flags_in[`BSF_FLAG_T];
        5'h06: flags_out[bit_idx] = 1'b1;
        5'h07: flags_out[bit_idx] = 1'b0;
        // unused codes leave both register and flags as they were
        default: begin
          data_out  = data_in;
          flags_out = flags_in;
        end
      endcase
    end
  end

endmodule

// ===== bsf_top.sv
// bit shift and flag unit with avalon-mm register access
//
// Overview of operation
// - rotate left: bits move up, old carry to bit 0, bit 7 to carry.
// - rotate right: bits move down, old carry to bit 7, bit 0 to carry.
// - arithmetic shift right: bits 1..7 move down one, bit 7 kept.
// - the three shifts update zero, carry, negative and overflow from the result.
// - nibble exchange swaps upper and lower halves, flags untouched, one cycle.
// - bit store copies the indexed register bit into the transfer flag.
// - bit load writes the transfer flag into the indexed bit only.
// - dedicated ops set or clear carry, negative, zero, signed, transfer, irq enable.
// - dedicated ops force overflow to one or zero, others unchanged.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "bsf_params.svh"

module bsf_top (
  input  wire logic        clk_sys,            // 50 mhz system clock
  input  wire logic        sys_rst,            // synchronous reset, active high
  input  wire logic [3:0]  avs_address,        // byte address
  input  wire logic        avs_read,           // read request
  input  wire logic        avs_write,          // write request
  input  wire logic [3:0]  avs_byteenable,     // write byte lanes
  input  wire logic [31:0] avs_writedata,      // write data
  output logic      [31:0] avs_readdata,       // read data
  output logic             avs_waitrequest,    // stall, low for the answer cycle
  output logic      [7:0]  status_flags,       // current status flags
  output logic      [7:0]  work_reg            // current working register
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  bsf_pkg::bsf_bus_state_t state_r, state_nxt;
  logic                    wait_r, wait_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  logic [7:0]              operand_r, operand_nxt;
  logic [7:0]              flags_r, flags_nxt;
  logic [10:0]             ctrl_r, ctrl_nxt;
  logic [7:0]              alu_data;
  logic [7:0]              alu_flags;
  logic [4:0]              op_w;
  logic [2:0]              idx_w;
  logic                    req;
  logic                    in_ack;
  logic                    exec_op;

  assign req     = avs_read | avs_write;
  assign in_ack  = (state_r == bsf_pkg::BUS_ACK);
  assign op_w    = avs_writedata[`BSF_CTRL_OP_MSB:`BSF_CTRL_OP_LSB];
  // index lane disabled means index zero
  assign idx_w   = avs_byteenable[1] ? avs_writedata[`BSF_CTRL_IDX_MSB:`BSF_CTRL_IDX_LSB]
                                     : 3'h0;
  // a control write is the instruction issue; it executes on its answer edge
  assign exec_op = in_ack && avs_write && avs_byteenable[0]
                   && (avs_address == `BSF_ADDR_CTRL);

  bsf_alu u_alu (
    .op        (op_w),
    .bit_idx   (idx_w),
    .data_in   (operand_r),
    .flags_in  (flags_r),
    .data_out  (alu_data),
    .flags_out (alu_flags)
  );

  function automatic logic [31:0] read_mux(input logic [3:0]  addr,
                                           input logic [7:0]  opnd,
                                           input logic [10:0] ctl,
                                           input logic [7:0]  flg);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (addr)
      `BSF_ADDR_OPERAND: d = {24'h00_0000, opnd};
      `BSF_ADDR_CTRL:    d = {21'h00_0000, ctl};
      `BSF_ADDR_FLAGS:   d = {24'h00_0000, flg};
      default:           d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then one answer cycle

  always_comb begin
    state_nxt = state_r;
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    unique case (state_r)
      bsf_pkg::BUS_IDLE: begin
        if (req) begin
          state_nxt = bsf_pkg::BUS_ACK;
          wait_nxt  = 1'b0;
          rdata_nxt = avs_read ? read_mux(avs_address, operand_r, ctrl_r, flags_r)
                               : 32'h0000_0000;
        end
      end
      bsf_pkg::BUS_ACK: begin
        // master releases after this edge; idle cycle keeps requests apart
        state_nxt = bsf_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= bsf_pkg::BUS_IDLE;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working register, flags and control word

  always_comb begin
    operand_nxt = operand_r;
    flags_nxt   = flags_r;
    ctrl_nxt    = ctrl_r;
    if (exec_op) begin
      ctrl_nxt    = {idx_w, 3'h0, op_w};
      operand_nxt = alu_data;
      flags_nxt   = alu_flags;
    end else if (in_ack && avs_write && avs_byteenable[0]) begin
      if (avs_address == `BSF_ADDR_OPERAND) begin
        operand_nxt = avs_writedata[7:0];
      end
      if (avs_address == `BSF_ADDR_FLAGS) begin
        flags_nxt = avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      operand_r <= `BSF_RST_OPERAND;
      flags_r   <= `BSF_RST_FLAGS;
      ctrl_r    <= `BSF_RST_CTRL;
    end else begin
      operand_r <= operand_nxt;
      flags_r   <= flags_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign status_flags    = flags_r;
  assign work_reg        = operand_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // snapshot of the state an instruction saw, for the checks only
  logic       chk_go_r;
  logic [4:0] chk_op_r;
  logic [2:0] chk_idx_r;
  logic [7:0] chk_d_r;
  logic [7:0] chk_f_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chk_go_r  <= 1'b0;
      chk_op_r  <= 5'h00;
      chk_idx_r <= 3'h0;
      chk_d_r   <= 8'h00;
      chk_f_r   <= 8'h00;
    end else begin
      chk_go_r  <= exec_op;
      chk_op_r  <= op_w;
      chk_idx_r <= idx_w;
      chk_d_r   <= operand_r;
      chk_f_r   <= flags_r;
    end
  end

  // flag each dedicated op forces, decoded apart from the datapath on purpose
  logic [7:0] chk_mask;

  always_comb begin
    chk_mask = 8'h00;
    unique case (chk_op_r[4:1])
      4'h4:    chk_mask = 8'h01 << `BSF_FLAG_C;
      4'h5:    chk_mask = 8'h01 << `BSF_FLAG_N;
      4'h6:    chk_mask = 8'h01 << `BSF_FLAG_Z;
      4'h7:    chk_mask = 8'h01 << `BSF_FLAG_I;
      4'h8:    chk_mask = 8'h01 << `BSF_FLAG_S;
      4'h9:    chk_mask = 8'h01 << `BSF_FLAG_V;
      4'hA:    chk_mask = 8'h01 << `BSF_FLAG_T;
      default: chk_mask = 8'h00;
    endcase
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_issue;
    !in_ack && req;
  endsequence

  sequence s_answer_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (s_issue |=> s_answer_done)
    else $error("waitrequest not low for exactly one cycle");

  a_rotate_left: assert property (chk_go_r && chk_op_r == 5'h00 |->
    operand_r == {chk_d_r[6:0], chk_f_r[0]} && flags_r[0] == chk_d_r[7])
    else $error("rotate left result wrong");

  a_rotate_right: assert property (chk_go_r && chk_op_r == 5'h01 |->
    operand_r == {chk_f_r[0], chk_d_r[7:1]} && flags_r[0] == chk_d_r[0])
    else $error("rotate right result wrong");

  a_arith_shift: assert property (chk_go_r && chk_op_r == 5'h02 |->
    operand_r == {chk_d_r[7], chk_d_r[7:1]})
    else $error("arithmetic shift result wrong");

  a_shift_flags: assert property (chk_go_r && chk_op_r <= 5'h02 |->
    flags_r[1] == (operand_r == 8'h00) && flags_r[2] == operand_r[7]
    && flags_r[3] == (operand_r[7] ^ flags_r[0]) && flags_r[7:4] == chk_f_r[7:4])
    else $error("shift flags wrong");

  a_nibble_swap: assert property (chk_go_r && chk_op_r == 5'h03 |->
    operand_r == {chk_d_r[3:0], chk_d_r[7:4]} && flags_r == chk_f_r)
    else $error("nibble exchange wrong");

  a_bit_store: assert property (chk_go_r && chk_op_r == 5'h04 |->
    flags_r[6] == chk_d_r[chk_idx_r] && operand_r == chk_d_r)
    else $error("bit store wrong");

  a_bit_load: assert property (chk_go_r && chk_op_r == 5'h05 |->
    operand_r[chk_idx_r] == chk_f_r[6] && flags_r == chk_f_r
    && ((operand_r ^ chk_d_r) & ~(8'h01 << chk_idx_r)) == 8'h00)
    else $error("bit load wrong");

  a_named_flags: assert property (chk_go_r && chk_op_r >= 5'h08 && chk_op_r <= 5'h15
    |-> operand_r == chk_d_r && $countones(flags_r ^ chk_f_r) <= 1
    && flags_r == (chk_op_r[0] ? (chk_f_r & ~chk_mask) : (chk_f_r | chk_mask)))
    else $error("named flag op touched more than one flag");

  a_overflow_force: assert property (chk_go_r && chk_op_r[4:1] == 4'h9 |->
    flags_r[3] == ~chk_op_r[0] && (flags_r & 8'hF7) == (chk_f_r & 8'hF7))
    else $error("overflow force wrong");

  a_generic_flag: assert property (chk_go_r && chk_op_r[4:1] == 4'h3 |->
    flags_r[chk_idx_r] == ~chk_op_r[0]
    && ((flags_r ^ chk_f_r) & ~(8'h01 << chk_idx_r)) == 8'h00)
    else $error("generic flag op wrong");

endmodule

// ===== bsf_host_model.sv
// avalon-mm master standing in for the instruction decoder and register file
`timescale 1ns/1ns

module bsf_host_model (
  input  wire logic        clk_sys,         // system clock
  output logic      [3:0]  avs_address,     // byte address
  output logic             avs_read,        // read request
  output logic             avs_write,       // write request
  output logic      [3:0]  avs_byteenable,  // write byte lanes
  output logic      [31:0] avs_writedata,   // write data
  input  wire logic [31:0] avs_readdata,    // read data
  input  wire logic        avs_waitrequest  // stall
);
  initial begin
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata  = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////
  // one access; request held until waitrequest is seen low
  task automatic access(input logic rd, input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= rd;
    avs_write      <= !rd;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // unqualified lines scrambled so stale values cannot pass
    avs_address   <= ~a;
    avs_writedata <= ~d;
    // one idle edge so the strobe is never re-raised in the same step
    @(posedge clk_sys);
  endtask
endmodule

// ===== bsf_top_bench.sv
// self-checking bench for the bit shift and flag unit
`timescale 1ns/1ns
`define BSF_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module bsf_top_bench;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  status_flags;
  logic [7:0]  work_reg;
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #10 clk_sys = ~clk_sys;

  bsf_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .status_flags(status_flags), .work_reg(work_reg));

  bsf_host_model u_host (.clk_sys(clk_sys), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // the whole run needs about a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    u_host.access(1'b0, a, d, be, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    u_host.access(1'b1, a, 32'h0000_0000, 4'hF, q);
  endtask

  // expected {flags, result}; flag order c z n v s h t i from bit 0
  function automatic logic [15:0] model(logic [4:0] op, logic [2:0] ix, logic [7:0] d,
                                        logic [7:0] f);
    logic [7:0]  r;
    logic [7:0]  g;
    logic [20:0] tbl;
    r = d;
    g = f;
    tbl = {3'h6, 3'h3, 3'h4, 3'h7, 3'h1, 3'h2, 3'h0};
    case (op)
      5'h00: begin r = {d[6:0], f[0]}; g[0] = d[7]; end
      5'h01: begin r = {f[0], d[7:1]}; g[0] = d[0]; end
      5'h02: begin r = {d[7], d[7:1]}; g[0] = d[0]; end
      5'h03: r = {d[3:0], d[7:4]};
      5'h04: g[6] = d[ix];
      5'h05: r[ix] = f[6];
      5'h06: g[ix] = 1'b1;
      5'h07: g[ix] = 1'b0;
      default: if (op <= 5'h15) g[tbl[3 * ((op - 5'h08) >> 1) +: 3]] = ~op[0];
    endcase
    if (op <= 5'h02) begin
      g[1] = (r == 8'h00);
      g[2] = r[7];
      g[3] = r[7] ^ g[0];
    end
    return {g, r};
  endfunction

  task automatic run(input logic [4:0] op, input logic [2:0] ix, input logic [7:0] d,
                     input logic [7:0] f);
    logic [15:0] e;
    e = model(op, ix, d, f);
    wr(4'h0, {24'h00_0000, d}, 4'h1);
    wr(4'h8, {24'h00_0000, f}, 4'h1);
    wr(4'h4, {21'h00_0000, ix, 3'h0, op}, 4'h3);
    `BSF_CHK("work_reg", e[7:0], work_reg)
    `BSF_CHK("status_flags", e[15:8], status_flags)
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] q;
    `BSF_CHK("work_reg", 8'h00, work_reg)
    `BSF_CHK("status_flags", 8'h00, status_flags)
    for (int a = 0; a < 12; a += 4) begin
      rd(4'(a), q);
      `BSF_CHK("reset readback", 32'h0000_0000, q)
    end
  endtask

  task automatic t_shifts();
    logic [7:0] v[4] = '{8'h80, 8'h01, 8'h00, 8'hA5};
    for (int op = 0; op < 3; op++)
      for (int i = 0; i < 8; i++)
        run(5'(op), 3'h0, v[i % 4], 8'h50 | 8'(i / 4));
  endtask

  task automatic t_swap();
    run(5'h03, 3'h0, 8'h3C, 8'hFF);
    run(5'h03, 3'h0, 8'hA5, 8'h00);
  endtask

  task automatic t_bits();
    for (int ix = 0; ix < 8; ix++) begin
      run(5'h04, 3'(ix), 8'h5A, 8'h00);
      run(5'h04, 3'(ix), 8'h5A, 8'hFF);
      run(5'h05, 3'(ix), 8'hA5, 8'h40);
      run(5'h05, 3'(ix), 8'hA5, 8'hBF);
    end
  endtask

  task automatic t_dedicated();
    for (int op = 8; op <= 21; op++) begin
      run(5'(op), 3'h5, 8'h33, 8'h55);
      run(5'(op), 3'h2, 8'h33, 8'hAA);
    end
  endtask

  task automatic t_generic();
    for (int ix = 0; ix < 8; ix++) begin
      run(5'h06, 3'(ix), 8'h11, 8'h00);
      run(5'h07, 3'(ix), 8'h11, 8'hFF);
    end
  endtask

  task automatic t_refused();
    logic [31:0] q;
    rd(4'hC, q);
    `BSF_CHK("unmapped read", 32'h0000_0000, q)
    run(5'h16, 3'h3, 8'h9C, 8'h81);
    rd(4'h4, q);
    `BSF_CHK("ctrl readback", 32'h0000_0316, q)
    wr(4'h0, 32'hFFFF_FFEE, 4'hE);
    rd(4'h0, q);
    `BSF_CHK("lane0 off write", 32'h0000_009C, q)
    wr(4'hC, 32'h0000_0077, 4'hF);
    rd(4'h8, q);
    `BSF_CHK("flags readback", 32'h0000_0081, q)
    // index lane off: index taken as zero, so carry is the flag cleared
    wr(4'h4, {21'h00_0000, 3'h5, 3'h0, 5'h07}, 4'h1);
    `BSF_CHK("status_flags", 8'h80, status_flags)
    rd(4'h4, q);
    `BSF_CHK("ctrl readback", 32'h0000_0007, q)
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_shifts();
    t_swap();
    t_bits();
    t_dedicated();
    t_generic();
    t_refused();
    test_done();
  end
endmodule
